/* File: hw/isp_dev_end.sv */
// register port end of the two-wire link, clocked by the serial clock, with its register outputs copied into the system clock domain
`timescale 1ns/100ps
module isp_dev_end (
  isp_link_if.dev                                  link,
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  output logic [isp_pkg::REG_COUNT-1:0][7:0]       regBank,
  output logic                                     regWrPulse,
  output logic [isp_pkg::PTR_W-1:0]                regWrIndex
);
  import isp_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  isp_dev_state_e                state_reg;
  isp_dev_state_e                stateNext;
  logic [2:0]                    bitCnt_reg;
  logic [2:0]                    bitCntNext;
  logic [7:0]                    shift_reg;
  logic [7:0]                    shiftNext;
  logic [7:0]                    rxByte;
  logic [PTR_W-1:0]              ptr_reg;
  logic [PTR_W-1:0]              ptrNext;
  logic                          isRead_reg;
  logic                          isReadNext;
  logic                          addrPhase_reg;
  logic                          addrPhaseNext;
  logic [REG_COUNT-1:0][7:0]     regs_reg;
  logic [REG_COUNT-1:0][7:0]     regsNext;
  logic [PTR_W-1:0]              wrIdx_reg;
  logic [PTR_W-1:0]              wrIdxNext;
  logic [7:0]                    wrData_reg;
  logic [7:0]                    wrDataNext;
  logic                          wrTgl_reg;
  logic                          wrTglNext;
  logic                          startTgl_reg;
  logic                          startTglNext;
  logic                          stopTgl_reg;
  logic                          stopTglNext;
  logic                          startAck_reg;
  logic                          stopAck_reg;
  logic                          startPend;
  logic                          stopPend;
  logic                          sdaLow_reg;
  logic                          sdaLowNext;
  logic [2:0]                    wrSync_reg;
  logic [2:0]                    wrSyncNext;
  logic [REG_COUNT-1:0][7:0]     bank_reg;
  logic [REG_COUNT-1:0][7:0]     bankNext;
  logic                          pulse_reg;
  logic                          pulseNext;
  logic [PTR_W-1:0]              index_reg;
  logic [PTR_W-1:0]              indexNext;

  // ---------------------------------------------------------------
  // start and stop detection on data-line edges
  // ---------------------------------------------------------------
  // each condition toggles a flag; the serial-clock logic compares it
  // with its own copy. the flags only move while the clock is high, so
  // they are settled long before the next rising clock edge.
  always_comb begin
    startTglNext = link.scl ? ~startTgl_reg : startTgl_reg;
    stopTglNext  = link.scl ? ~stopTgl_reg : stopTgl_reg;
  end

  always_ff @(negedge link.sda or negedge rst_n) begin
    if (!rst_n) begin
      startTgl_reg <= 1'b0;
    end else begin
      startTgl_reg <= startTglNext;
    end
  end

  always_ff @(posedge link.sda or negedge rst_n) begin
    if (!rst_n) begin
      stopTgl_reg <= 1'b0;
    end else begin
      stopTgl_reg <= stopTglNext;
    end
  end

  assign startPend = startTgl_reg != startAck_reg;
  assign stopPend  = stopTgl_reg != stopAck_reg;

  // ---------------------------------------------------------------
  // byte engine, bits sampled on the rising serial clock
  // ---------------------------------------------------------------
  always_comb begin
    stateNext     = state_reg;
    bitCntNext    = bitCnt_reg;
    shiftNext     = shift_reg;
    ptrNext       = ptr_reg;
    isReadNext    = isRead_reg;
    addrPhaseNext = addrPhase_reg;
    regsNext      = regs_reg;
    wrIdxNext     = wrIdx_reg;
    wrDataNext    = wrData_reg;
    wrTglNext     = wrTgl_reg;
    rxByte        = {shift_reg[6:0], link.sda};
    if (startPend) begin
      // a start, also a repeated one, opens a new address byte
      stateNext  = ISP_DS_ADDR;
      bitCntNext = 3'h1;
      shiftNext  = {7'h00, link.sda};
    end else if (stopPend) begin
      stateNext = ISP_DS_IDLE;
    end else begin
      case (state_reg)
        ISP_DS_IDLE: begin
          stateNext = ISP_DS_IDLE;
        end
        ISP_DS_ADDR: begin
          shiftNext  = rxByte;
          bitCntNext = bitCnt_reg + 3'h1;
          if (bitCnt_reg == BIT_LAST) begin
            if (rxByte[7:1] == SLAVE_ADDR) begin
              stateNext     = ISP_DS_ADDR_AK;
              isReadNext    = rxByte[0];
              addrPhaseNext = ~rxByte[0];
            end else begin
              stateNext = ISP_DS_IDLE;
            end
          end
        end
        ISP_DS_ADDR_AK, ISP_DS_RX_AK: begin
          bitCntNext = 3'h0;
          if (isRead_reg) begin
            stateNext = ISP_DS_TX;
            shiftNext = regs_reg[ptr_reg];
          end else begin
            stateNext = ISP_DS_RX;
          end
        end
        ISP_DS_RX: begin
          shiftNext  = rxByte;
          bitCntNext = bitCnt_reg + 3'h1;
          if (bitCnt_reg == BIT_LAST) begin
            stateNext = ISP_DS_RX_AK;
            if (addrPhase_reg) begin
              ptrNext       = rxByte[PTR_W-1:0];
              addrPhaseNext = 1'b0;
            end else begin
              regsNext[ptr_reg] = rxByte;
              wrIdxNext         = ptr_reg;
              wrDataNext        = rxByte;
              wrTglNext         = ~wrTgl_reg;
              ptrNext           = ptr_reg + PTR_STEP;
            end
          end
        end
        ISP_DS_TX: begin
          shiftNext  = {shift_reg[6:0], 1'b1};
          bitCntNext = bitCnt_reg + 3'h1;
          if (bitCnt_reg == BIT_LAST) begin
            stateNext = ISP_DS_TX_AK;
            ptrNext   = ptr_reg + PTR_STEP;
          end
        end
        ISP_DS_TX_AK: begin
          bitCntNext = 3'h0;
          if (!link.sda) begin
            // master acknowledged: keep sending, even past its last byte
            stateNext = ISP_DS_TX;
            shiftNext = regs_reg[ptr_reg];
          end else begin
            stateNext = ISP_DS_IDLE;
          end
        end
        default: begin
          stateNext = ISP_DS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ISP_DS_IDLE;
      bitCnt_reg    <= 3'h0;
      shift_reg     <= 8'h00;
      ptr_reg       <= '0;
      isRead_reg    <= 1'b0;
      addrPhase_reg <= 1'b0;
      regs_reg      <= REG_RESET;
      wrIdx_reg     <= '0;
      wrData_reg    <= 8'h00;
      wrTgl_reg     <= 1'b0;
      startAck_reg  <= 1'b0;
      stopAck_reg   <= 1'b0;
    end else begin
      state_reg     <= stateNext;
      bitCnt_reg    <= bitCntNext;
      shift_reg     <= shiftNext;
      ptr_reg       <= ptrNext;
      isRead_reg    <= isReadNext;
      addrPhase_reg <= addrPhaseNext;
      regs_reg      <= regsNext;
      wrIdx_reg     <= wrIdxNext;
      wrData_reg    <= wrDataNext;
      wrTgl_reg     <= wrTglNext;
      startAck_reg  <= startTgl_reg;
      stopAck_reg   <= stopTgl_reg;
    end
  end

  // ---------------------------------------------------------------
  // data-line drive, changed on the falling serial clock
  // ---------------------------------------------------------------
  always_comb begin
    sdaLowNext = (state_reg == ISP_DS_ADDR_AK) ||
                 (state_reg == ISP_DS_RX_AK) ||
                 ((state_reg == ISP_DS_TX) && !shift_reg[7]);
    if (startPend || stopPend) begin
      sdaLowNext = 1'b0;
    end
  end

  always_ff @(negedge link.scl or negedge rst_n) begin
    if (!rst_n) begin
      sdaLow_reg <= 1'b0;
    end else begin
      sdaLow_reg <= sdaLowNext;
    end
  end

  // open drain: only low or released
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe  = sdaLow_reg;

  // ---------------------------------------------------------------
  // register copy in the system clock domain
  // ---------------------------------------------------------------
  // index and data are held for a whole byte time after each toggle,
  // far longer than the three-flop path, so they are read directly.
  always_comb begin
    wrSyncNext = {wrSync_reg[1:0], wrTgl_reg};
    bankNext   = bank_reg;
    pulseNext  = 1'b0;
    indexNext  = index_reg;
    if (wrSync_reg[2] != wrSync_reg[1]) begin
      bankNext[wrIdx_reg] = wrData_reg;
      pulseNext           = 1'b1;
      indexNext           = wrIdx_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrSync_reg <= 3'h0;
      bank_reg   <= REG_RESET;
      pulse_reg  <= 1'b0;
      index_reg  <= '0;
    end else begin
      wrSync_reg <= wrSyncNext;
      bank_reg   <= bankNext;
      pulse_reg  <= pulseNext;
      index_reg  <= indexNext;
    end
  end

  assign regBank    = bank_reg;
  assign regWrPulse = pulse_reg;
  assign regWrIndex = index_reg;

endmodule

/* File: hw/isp_host_end.sv */
// master end of the two-wire link: makes the serial clock by division
`timescale 1ns/100ps
module isp_host_end #(
  parameter int QUARTER = isp_pkg::QUARTER_CYC
) (
  isp_link_if.host                  link,
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 cmdValid,
  output logic                      cmdReady,
  input  wire isp_pkg::isp_op_e     cmdOp,
  input  wire logic [7:0]           cmdData,
  input  wire logic                 cmdNack,
  output logic                      rspValid,
  output logic [7:0]                rspData,
  output logic                      rspAck
);
  import isp_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam int QW = $clog2(QUARTER + 1);

  isp_host_state_e   state_reg;
  isp_host_state_e   stateNext;
  logic [QW-1:0]     qCnt_reg;
  logic [QW-1:0]     qCntNext;
  logic [1:0]        phase_reg;
  logic [1:0]        phaseNext;
  logic [3:0]        bitCnt_reg;
  logic [3:0]        bitCntNext;
  logic [8:0]        tx_reg;
  logic [8:0]        txNext;
  logic [8:0]        rx_reg;
  logic [8:0]        rxNext;
  logic              sclLow_reg;
  logic              sclLowNext;
  logic              sdaLow_reg;
  logic              sdaLowNext;
  logic [1:0]        sdaSync_reg;
  logic              ready_reg;
  logic              readyNext;
  logic              rspV_reg;
  logic              rspVNext;
  logic [7:0]        rspD_reg;
  logic [7:0]        rspDNext;
  logic              rspA_reg;
  logic              rspANext;
  logic              tick;
  logic              enter;

  assign tick = qCnt_reg == QW'(QUARTER - 1);

  // ---------------------------------------------------------------
  // sequencer: every condition and bit is four quarters
  // ---------------------------------------------------------------
  always_comb begin
    stateNext  = state_reg;
    qCntNext   = '0;
    phaseNext  = phase_reg;
    bitCntNext = bitCnt_reg;
    txNext     = tx_reg;
    rxNext     = rx_reg;
    sclLowNext = sclLow_reg;
    sdaLowNext = sdaLow_reg;
    readyNext  = ready_reg;
    rspVNext   = 1'b0;
    rspDNext   = rspD_reg;
    rspANext   = rspA_reg;
    enter      = 1'b0;
    if (state_reg == ISP_HS_IDLE) begin
      if (cmdValid && ready_reg) begin
        readyNext  = 1'b0;
        enter      = 1'b1;
        phaseNext  = 2'h0;
        bitCntNext = 4'h0;
        case (cmdOp)
          ISP_OP_START: stateNext = ISP_HS_START;
          ISP_OP_STOP:  stateNext = ISP_HS_STOP;
          ISP_OP_WRITE: begin
            stateNext = ISP_HS_XFER;
            txNext    = {cmdData, 1'b1};
          end
          default: begin
            stateNext = ISP_HS_XFER;
            txNext    = {8'hff, cmdNack};
          end
        endcase
      end
    end else begin
      qCntNext = tick ? '0 : qCnt_reg + QW'(1);
      if (tick) begin
        if (phase_reg != 2'h3) begin
          phaseNext = phase_reg + 2'h1;
          enter     = 1'b1;
        end else if (state_reg == ISP_HS_XFER && bitCnt_reg != HBIT_LAST) begin
          bitCntNext = bitCnt_reg + 4'h1;
          txNext     = {tx_reg[7:0], 1'b1};
          phaseNext  = 2'h0;
          enter      = 1'b1;
        end else begin
          stateNext = ISP_HS_IDLE;
          readyNext = 1'b1;
          if (state_reg == ISP_HS_XFER) begin
            rspVNext = 1'b1;
            rspDNext = rx_reg[8:1];
            rspANext = rx_reg[0];
          end
        end
      end
    end
    if (enter) begin
      case (phaseNext)
        2'h0: sclLowNext = 1'b1;
        2'h1: begin
          // bit data only moves while the clock is low; start and stop also move it in the last quarter, clock high
          case (stateNext)
            ISP_HS_START: sdaLowNext = 1'b0;
            ISP_HS_STOP:  sdaLowNext = 1'b1;
            default:      sdaLowNext = ~txNext[8];
          endcase
        end
        2'h2: sclLowNext = 1'b0;
        default: begin
          case (stateNext)
            ISP_HS_START: sdaLowNext = 1'b1;
            ISP_HS_STOP:  sdaLowNext = 1'b0;
            default:      rxNext     = {rx_reg[7:0], sdaSync_reg[1]};
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ISP_HS_IDLE;
      qCnt_reg    <= '0;
      phase_reg   <= 2'h0;
      bitCnt_reg  <= 4'h0;
      tx_reg      <= 9'h1ff;
      rx_reg      <= 9'h000;
      sclLow_reg  <= 1'b0;
      sdaLow_reg  <= 1'b0;
      sdaSync_reg <= 2'h3;
      ready_reg   <= 1'b1;
      rspV_reg    <= 1'b0;
      rspD_reg    <= 8'h00;
      rspA_reg    <= 1'b1;
    end else begin
      state_reg   <= stateNext;
      qCnt_reg    <= qCntNext;
      phase_reg   <= phaseNext;
      bitCnt_reg  <= bitCntNext;
      tx_reg      <= txNext;
      rx_reg      <= rxNext;
      sclLow_reg  <= sclLowNext;
      sdaLow_reg  <= sdaLowNext;
      sdaSync_reg <= {sdaSync_reg[0], link.sda};
      ready_reg   <= readyNext;
      rspV_reg    <= rspVNext;
      rspD_reg    <= rspDNext;
      rspA_reg    <= rspANext;
    end
  end

  assign link.sclOut     = 1'b0;
  assign link.sclOe      = sclLow_reg;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe  = sdaLow_reg;
  assign cmdReady        = ready_reg;
  assign rspValid        = rspV_reg;
  assign rspData         = rspD_reg;
  assign rspAck          = rspA_reg;

endmodule

/* File: hw/isp_link_if.sv */
// two-wire link between the register port and its master
`timescale 1ns/100ps
interface isp_link_if;
  logic sclOut;
  logic sclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups
  assign scl = sclOe ? sclOut : 1'b1;
  assign sda = (hostSdaOe ? hostSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);

  modport dev (
    input  scl,
    input  sda,
    output devSdaOut,
    output devSdaOe
  );

  modport host (
    input  sda,
    output sclOut,
    output sclOe,
    output hostSdaOut,
    output hostSdaOe
  );
endinterface

/* File: hw/isp_pkg.sv */
// shared constants and types for the two-wire register port and its master
package isp_pkg;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int                    REG_COUNT  = 8;
  localparam int                    PTR_W      = 3;
  localparam logic [6:0]            SLAVE_ADDR = 7'h09;
  localparam logic [PTR_W-1:0]      PTR_STEP   = 3'h1;
  localparam logic [2:0]            BIT_LAST   = 3'h7;
  localparam logic [3:0]            HBIT_LAST  = 4'h8;
  // register 0 holds 20h after reset, all others 00h
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20
  };

  // ---------------------------------------------------------------
  // master timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // one quarter of a bit; two quarters cover the longest low/high minimum
  localparam int QUARTER_NS    = 4700;
  localparam int QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ISP_DS_IDLE    = 3'b000,
    ISP_DS_ADDR    = 3'b001,
    ISP_DS_ADDR_AK = 3'b010,
    ISP_DS_RX      = 3'b011,
    ISP_DS_RX_AK   = 3'b100,
    ISP_DS_TX      = 3'b101,
    ISP_DS_TX_AK   = 3'b110
  } isp_dev_state_e;

  typedef enum logic [1:0] {
    ISP_OP_START = 2'b00,
    ISP_OP_STOP  = 2'b01,
    ISP_OP_WRITE = 2'b10,
    ISP_OP_READ  = 2'b11
  } isp_op_e;

  typedef enum logic [1:0] {
    ISP_HS_IDLE  = 2'b00,
    ISP_HS_START = 2'b01,
    ISP_HS_XFER  = 2'b10,
    ISP_HS_STOP  = 2'b11
  } isp_host_state_e;

endpackage

/* File: testbench/i2c_slave_register_port_tb_top.sv */
// self-checking bench joining the master end and the register port on one link
`timescale 1ns/100ps
module i2c_slave_register_port_tb_top;
  import isp_pkg::*;
  // ----
  // signals and instances
  // ----
  logic                      clock, rst_n, cmdValid, cmdReady, cmdNack;
  logic                      rspValid, rspAck, regWrPulse;
  isp_op_e                   cmdOp;
  logic [7:0]                cmdData, rspData;
  logic [REG_COUNT-1:0][7:0] regBank;
  logic [PTR_W-1:0]          regWrIndex;
  logic [7:0]                mdl [REG_COUNT];
  int                        errCount = 0;
  int                        checksDone = 0;
  int                        cycles = 0;
  logic [7:0]                wrPulses = 8'h00;

  isp_link_if link ();
  isp_dev_end u_isp_dev_end (
    .link       (link),
    .clock      (clock),
    .rst_n      (rst_n),
    .regBank    (regBank),
    .regWrPulse (regWrPulse),
    .regWrIndex (regWrIndex)
  );
  isp_host_end #(.QUARTER(4)) u_isp_host_end (
    .link     (link),
    .clock    (clock),
    .rst_n    (rst_n),
    .cmdValid (cmdValid),
    .cmdReady (cmdReady),
    .cmdOp    (cmdOp),
    .cmdData  (cmdData),
    .cmdNack  (cmdNack),
    .rspValid (rspValid),
    .rspData  (rspData),
    .rspAck   (rspAck)
  );
  isp_link_assertions u_isp_link_assertions (
    .clock     (clock),
    .rst_n     (rst_n),
    .scl       (link.scl),
    .sda       (link.sda),
    .devSdaOut (link.devSdaOut),
    .devSdaOe  (link.devSdaOe)
  );
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    if (errCount == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one master command, waited for under a bounded count
  task automatic xfer(input isp_op_e op, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdData <= d;
    cmdNack <= nk;
    @(posedge clock);
    cmdValid <= 1'b0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (cmdReady !== 1'b1 && n < 200);
    chk("cmdReady", 8'h01, {7'h0, cmdReady});
    if (op[1]) chk("rspValid", 8'h01, {7'h0, rspValid});
  endtask

  task automatic wr(input logic [7:0] d, input logic expAck);
    xfer(ISP_OP_WRITE, d, 1'b0);
    chk("ack", {7'h0, expAck}, {7'h0, rspAck});
  endtask

  task automatic rd(input logic nk, input logic [7:0] exp);
    xfer(ISP_OP_READ, 8'h00, nk);
    chk("read data", exp, rspData);
  endtask

  task automatic head(input logic rw);
    xfer(ISP_OP_START, 8'h00, 1'b0);
    wr({SLAVE_ADDR, rw}, 1'b0);
  endtask

  task automatic bank();
    for (int i = 0; i < REG_COUNT; i++) chk("regBank", mdl[i], regBank[i]);
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < REG_COUNT; i++) mdl[i] = REG_RESET[i];
    #1;
    bank();
    @(posedge clock);
    rst_n <= 1'b1;
  endtask
  // ----
  // clock, timeout and sequence
  // ----
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // counts register copy updates seen by the system side
  always @(posedge clock) begin
    if (regWrPulse === 1'b1) begin
      wrPulses <= wrPulses + 8'h01;
    end
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errCount++;
      close_out();
    end
  end

  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdOp = ISP_OP_START;
    cmdData = 8'h00;
    cmdNack = 1'b0;
    do_reset();
    head(1'b0);
    wr(8'h06, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(8'ha0 + 8'(i), 1'b0);
      mdl[(6 + i) % REG_COUNT] = 8'ha0 + 8'(i);
    end
    xfer(ISP_OP_STOP, 8'h00, 1'b0);
    bank();
    chk("regWrIndex", 8'h01, {5'h0, regWrIndex});
    chk("regWrPulse count", 8'h04, wrPulses);
    // random read across the wrap; only the low pointer bits count
    head(1'b0);
    wr(8'hf7, 1'b0);
    head(1'b1);
    rd(1'b0, mdl[7]);
    rd(1'b0, mdl[0]);
    rd(1'b1, mdl[1]);
    xfer(ISP_OP_STOP, 8'h00, 1'b0);
    head(1'b1);
    rd(1'b1, mdl[2]);
    xfer(ISP_OP_STOP, 8'h00, 1'b0);
    // every single-bit address error, write for even bits and read for odd bits
    for (int b = 0; b < 7; b++) begin
      xfer(ISP_OP_START, 8'h00, 1'b0);
      wr({SLAVE_ADDR ^ 7'(1 << b), b[0]}, 1'b1);
      wr(8'h00, 1'b1);
      wr(8'h5a, 1'b1);
      xfer(ISP_OP_STOP, 8'h00, 1'b0);
    end
    bank();
    wr({SLAVE_ADDR, 1'b0}, 1'b1);
    wr(8'h00, 1'b1);
    xfer(ISP_OP_STOP, 8'h00, 1'b0);
    // reset in mid-write, then read from the reset pointer
    head(1'b0);
    wr(8'h03, 1'b0);
    wr(8'hc3, 1'b0);
    do_reset();
    head(1'b1);
    rd(1'b1, mdl[0]);
    xfer(ISP_OP_STOP, 8'h00, 1'b0);
    bank();
    chk("regWrPulse count", 8'h05, wrPulses);
    close_out();
  end
endmodule

/* File: testbench/isp_link_assertions.sv */
// concurrent checks on the two-wire link between master and register port
`timescale 1ns/100ps
module isp_link_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSdaOut,
  input wire logic devSdaOe
);
  import isp_pkg::*;
  // ----
  // bus tracking
  // ----
  logic       sclPrev_reg, sdaPrev_reg, first_reg, first_next, startSeen, stopSeen;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [1:0] mode_reg, mode_next;

  assign startSeen = scl & sclPrev_reg & sdaPrev_reg & ~sda;
  assign stopSeen  = scl & sclPrev_reg & ~sdaPrev_reg & sda;

  // mode: 0 none, 1 write, 2 read, 3 foreign address
  always_comb begin
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    mode_next = mode_reg;
    first_next = first_reg;
    if (scl && !sclPrev_reg) begin
      bitCnt_next = (bitCnt_reg == 4'h9) ? 4'h1 : bitCnt_reg + 4'h1;
      if (bitCnt_next != 4'h9) begin
        shift_next = {shift_reg[6:0], sda};
      end
    end
    if (!scl && sclPrev_reg && bitCnt_reg == 4'h8 && first_reg) begin
      mode_next = (shift_reg[7:1] != SLAVE_ADDR) ? 2'h3 : {shift_reg[0], ~shift_reg[0]};
    end
    if (!scl && sclPrev_reg && bitCnt_reg == 4'h9) begin
      first_next = 1'b0;
    end
    if (startSeen || stopSeen) begin
      bitCnt_next = 4'h0;
      mode_next = 2'h0;
      first_next = startSeen;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      first_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      mode_reg <= 2'h0;
    end else begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sda;
      first_reg <= first_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      mode_reg <= mode_next;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence ackSlot;
    $fell(scl) && bitCnt_reg == 4'h8;
  endsequence

  sequence ackDone;
    $fell(scl) && bitCnt_reg == 4'h9;
  endsequence

  dev_low_only_a: assert property (devSdaOe |-> !devSdaOut)
    else $error("device drives data high");
  dev_hold_a: assert property ($changed(devSdaOe) |-> $fell(scl))
    else $error("device data moved outside clock fall");
  addr_ack_a: assert property (ackSlot ##0 first_reg |->
    devSdaOe == (shift_reg[7:1] == SLAVE_ADDR))
    else $error("address acknowledge wrong");
  data_ack_a: assert property (ackSlot ##0 (!first_reg && mode_reg == 2'h1) |-> devSdaOe)
    else $error("write byte not acknowledged");
  rd_release_a: assert property (ackSlot ##0 (!first_reg && mode_reg == 2'h2) |-> !devSdaOe)
    else $error("data not released for master answer");
  wr_ack_end_a: assert property (ackDone ##0 mode_reg == 2'h1 |-> !devSdaOe)
    else $error("acknowledge held too long");
  foreign_quiet_a: assert property (mode_reg == 2'h3 |-> !devSdaOe)
    else $error("device drives after foreign address");
  idle_quiet_a: assert property (mode_reg == 2'h0 && !first_reg |-> !devSdaOe)
    else $error("device drives on idle bus");
  ack_stand_a: assert property ($rose(devSdaOe) |=> $stable(devSdaOe) [*8])
    else $error("device drive too short");
endmodule
